// file: rtl/ues_regs.svh
// Purpose: Register offsets, field positions, reset values and timing of the USB error block.
// Assumes: Included by its bare name after the package.
// Notes:   Definitions only.
`ifndef UES_REGS_SVH
`define UES_REGS_SVH

`define UES_ADDR_W       2
`define UES_OFS_FLAGS    2'h0
`define UES_OFS_ENABLES  2'h1
`define UES_OFS_MAIN_FLG 2'h2
`define UES_OFS_MAIN_EN  2'h3

`define UES_BIT_STUFF    7
`define UES_BIT_BUFFER   5
`define UES_BIT_TIMEOUT  4
`define UES_BIT_PARTIAL  3
`define UES_BIT_DATA_CHECKSUM_ERROR_ENABLE    2
`define UES_BIT_TOKEN_CHECKSUM_ERROR_ENABLE     1
`define UES_BIT_PID      0
`define UES_BIT_SUMMARY  1

`define UES_FLAGS_RST    8'h00
`define UES_ENABLES_RST  8'h00
`define UES_MAIN_EN_RST  8'h00
`define UES_IMPL_MASK    8'hBF
`define UES_SUMMARY_MASK 8'h02

`define UES_CLK_MHZ      7'h64
`define UES_BIT_MHZ      7'h0C
`define UES_TA_BITS      5'h10
`define UES_CNT_W        10

`endif

// file: rtl/ues_pkg.sv
// Purpose: Types shared by the USB error status block.
// Assumes: Nothing.
// Notes:   Constants live in ues_regs.svh.
package ues_pkg;
   typedef logic [7:0] ues_byte_t;
   typedef enum logic [0:0] {
      UES_TA_IDLE = 1'b0,
      UES_TA_RUN  = 1'b1
   } ues_ta_state_e;
endpackage

// file: rtl/ues_error_status.sv
// Purpose: Sticky USB error flags, their enables and the summary error bit.
// Assumes: All inputs synchronous to clk_in; event inputs are one-cycle pulses.
// Notes:   Registers sit on a plain strobe port with read data one cycle later.
//
// What this block does
// - Enabled error flags ORed into summary bit.
// - Flags clear only by writing one.
// - Flags set as soon as detected.
// - Error flags read zero after reset.
// - Bit stuffing error sets bit 7, rejects.
// - Late descriptor fetch sets buffer bit 5.
// - Oversize packet sets bit 5, truncates.
// - Turnaround timer between phases, timeout bit 4.
// - Timeout after over 16 idle bit times.
// - Partial byte data field sets bit 3.
// - Data checksum failure rejects, sets bit 2.
// - Token checksum failure rejects, sets bit 1.
// - Identifier check failure sets bit 0.
// - Enable bits at matching flag positions.
// - Summary bit 1 set by enabled errors.
// - Summary interrupt needs main enable bit 1.
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ues_regs.svh"

module ues_error_status (
   input  wire logic                          clk_in,
   input  wire logic                          rst_n_in,
   input  wire logic [`UES_ADDR_W-1:0]        addr_in,
   input  wire ues_pkg::ues_byte_t            wr_data_in,
   input  wire logic                          wr_en_in,
   input  wire logic                          rd_en_in,
   output var  ues_pkg::ues_byte_t            rd_data_out,
   input  wire logic                          bit_stuff_err_in,
   input  wire logic                          bd_fetch_late_in,
   input  wire logic                          packet_start_in,
   input  wire logic                          rx_byte_in,
   input  wire logic [`UES_CNT_W-1:0]         bd_size_in,
   input  wire logic                          rx_eop_in,
   input  wire logic [2:0]                    rx_bit_residue_in,
   input  wire logic                          data_checksum_error_enable_fail_in,
   input  wire logic                          token_checksum_error_enable_fail_in,
   input  wire logic                          pid_fail_in,
   input  wire logic                          eop_in,
   input  wire logic                          turnaround_expect_in,
   input  wire logic                          bus_idle_in,
   output logic                               store_byte_out,
   output logic                               packet_reject_out,
   output logic                               summary_error_flag_out,
   output logic                               error_irq_out
);
   import ues_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Register state and bus decode.

   ues_byte_t                  flags_reg;
   ues_byte_t                  flags_next;
   ues_byte_t                  enables_reg;
   ues_byte_t                  main_en_reg;
   ues_byte_t                  enables_next;
   ues_byte_t                  main_en_next;
   ues_byte_t                  set_vec;
   ues_byte_t                  clr_vec;
   logic                       wr_flags;
   logic                       wr_enables;
   logic                       wr_main_en;
   logic                       summary_next;
   logic                       buf_overrun;
   logic                       ta_timeout;
   logic [`UES_CNT_W-1:0]      byte_cnt_reg;
   logic [6:0]                 tick_acc_reg;
   logic                       bit_tick;
   logic [4:0]                 ta_cnt_reg;
   ues_ta_state_e              ta_state_reg;

   assign wr_flags   = wr_en_in && (addr_in == `UES_OFS_FLAGS);
   assign wr_enables = wr_en_in && (addr_in == `UES_OFS_ENABLES);
   assign wr_main_en = wr_en_in && (addr_in == `UES_OFS_MAIN_EN);
   assign clr_vec    = wr_flags ? (wr_data_in & `UES_IMPL_MASK) : `UES_FLAGS_RST;

   ////////////////////////////////////////////////////////////////////////////////
   // Error event sources.

   always_comb begin
      set_vec                   = `UES_FLAGS_RST;
      set_vec[`UES_BIT_STUFF]   = bit_stuff_err_in;
      set_vec[`UES_BIT_BUFFER]  = bd_fetch_late_in || buf_overrun;
      set_vec[`UES_BIT_TIMEOUT] = ta_timeout;
      set_vec[`UES_BIT_PARTIAL] = rx_eop_in && (rx_bit_residue_in != 3'h0);
      set_vec[`UES_BIT_DATA_CHECKSUM_ERROR_ENABLE]   = data_checksum_error_enable_fail_in;
      set_vec[`UES_BIT_TOKEN_CHECKSUM_ERROR_ENABLE]    = token_checksum_error_enable_fail_in;
      set_vec[`UES_BIT_PID]     = pid_fail_in;
   end

   // A set in the same cycle as a clear wins, so no event is lost.
   assign flags_next = ((flags_reg & ~clr_vec) | set_vec) & `UES_IMPL_MASK;

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_flag
         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               flags_reg[gi] <= 1'(`UES_FLAGS_RST >> gi);
            end else begin
               flags_reg[gi] <= flags_next[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         enables_reg <= `UES_ENABLES_RST;
      end else if (wr_enables) begin
         enables_reg <= wr_data_in & `UES_IMPL_MASK;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         main_en_reg <= `UES_MAIN_EN_RST;
      end else if (wr_main_en) begin
         main_en_reg <= wr_data_in & `UES_SUMMARY_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Summary error bit and its interrupt.

   // The summary follows an enable write in the same edge, so it never lags the register.
   assign enables_next = wr_enables ? (wr_data_in & `UES_IMPL_MASK) : enables_reg;
   assign main_en_next = wr_main_en ? (wr_data_in & `UES_SUMMARY_MASK) : main_en_reg;
   assign summary_next = |(flags_next & enables_next);

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         summary_error_flag_out <= 1'b0;
         error_irq_out          <= 1'b0;
      end else begin
         summary_error_flag_out <= summary_next;
         error_irq_out          <= summary_next && main_en_next[`UES_BIT_SUMMARY];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read port.

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_data_out <= 8'h00;
      end else if (rd_en_in) begin
         unique case (addr_in)
            `UES_OFS_FLAGS:    rd_data_out <= flags_reg;
            `UES_OFS_ENABLES:  rd_data_out <= enables_reg;
            `UES_OFS_MAIN_FLG: rd_data_out <= {6'h00, summary_error_flag_out, 1'b0};
            `UES_OFS_MAIN_EN:  rd_data_out <= main_en_reg;
         endcase
      end else begin
         rd_data_out <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Packet rejection and buffer truncation.

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         packet_reject_out <= 1'b0;
      end else begin
         packet_reject_out <= bit_stuff_err_in || data_checksum_error_enable_fail_in || token_checksum_error_enable_fail_in;
      end
   end

   assign buf_overrun = rx_byte_in && (byte_cnt_reg >= bd_size_in);

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         byte_cnt_reg <= '0;
      end else if (packet_start_in) begin
         byte_cnt_reg <= '0;
      end else if (rx_byte_in && !(&byte_cnt_reg)) begin
         byte_cnt_reg <= byte_cnt_reg + `UES_CNT_W'(1);
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         store_byte_out <= 1'b0;
      end else begin
         store_byte_out <= rx_byte_in && !buf_overrun;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Bit-time enable: fractional divider from the module clock to the bus bit rate.

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tick_acc_reg <= 7'h00;
      end else if (ta_state_reg == UES_TA_IDLE) begin
         tick_acc_reg <= 7'h00;
      end else if (tick_acc_reg + `UES_BIT_MHZ >= `UES_CLK_MHZ) begin
         tick_acc_reg <= tick_acc_reg + `UES_BIT_MHZ - `UES_CLK_MHZ;
      end else begin
         tick_acc_reg <= tick_acc_reg + `UES_BIT_MHZ;
      end
   end

   assign bit_tick = (ta_state_reg == UES_TA_RUN)
                     && (tick_acc_reg + `UES_BIT_MHZ >= `UES_CLK_MHZ);

   ////////////////////////////////////////////////////////////////////////////////
   // Bus turnaround timer.

   assign ta_timeout = (ta_state_reg == UES_TA_RUN) && bus_idle_in && bit_tick
                       && (ta_cnt_reg == `UES_TA_BITS);

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ta_state_reg <= UES_TA_IDLE;
         ta_cnt_reg   <= 5'h00;
      end else begin
         unique case (ta_state_reg)
            UES_TA_IDLE: begin
               ta_cnt_reg <= 5'h00;
               if (eop_in && turnaround_expect_in) begin
                  ta_state_reg <= UES_TA_RUN;
               end
            end
            UES_TA_RUN: begin
               if (!bus_idle_in || ta_timeout) begin
                  ta_state_reg <= UES_TA_IDLE;
               end else if (bit_tick) begin
                  ta_cnt_reg <= ta_cnt_reg + 5'h01;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions and covers.

   a_flag_sticky: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      1'b1 |=> ((flags_reg & $past(flags_reg & ~clr_vec)) == $past(flags_reg & ~clr_vec)))
      else $error("Error flag dropped without a write of one.");

   a_flag_clear_only: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ($past(flags_reg) & ~flags_reg) == ($past(flags_reg) & ~flags_reg & $past(clr_vec)))
      else $error("Error flag cleared by something other than a write.");

   a_flags_reset: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      $rose(rst_n_in) |-> (flags_reg == 8'h00))
      else $error("Error flags not zero after reset.");

   a_unimpl_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !flags_reg[6] && !enables_reg[6])
      else $error("Unimplemented bit 6 is set.");

   a_summary_or: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      summary_error_flag_out == |(flags_reg & enables_reg))
      else $error("Summary bit does not match enabled flags.");

   a_irq_gate: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      error_irq_out == (summary_error_flag_out && main_en_reg[`UES_BIT_SUMMARY]))
      else $error("Error interrupt not gated by main enable.");

   a_stuff_reject: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      bit_stuff_err_in |=> flags_reg[`UES_BIT_STUFF] && packet_reject_out)
      else $error("Bit stuffing error not flagged and rejected.");

   a_bd_late: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      bd_fetch_late_in |=> flags_reg[`UES_BIT_BUFFER])
      else $error("Late descriptor fetch not flagged.");

   a_buf_truncate: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (rx_byte_in && (byte_cnt_reg >= bd_size_in))
      |=> !store_byte_out && flags_reg[`UES_BIT_BUFFER])
      else $error("Oversize byte stored or not flagged.");

   a_partial_byte: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (rx_eop_in && (rx_bit_residue_in != 3'h0)) |=> flags_reg[`UES_BIT_PARTIAL])
      else $error("Partial byte data field not flagged.");

   a_data_checksum_error_enable_reject: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      data_checksum_error_enable_fail_in |=> flags_reg[`UES_BIT_DATA_CHECKSUM_ERROR_ENABLE] && packet_reject_out)
      else $error("Data checksum failure not flagged and rejected.");

   a_token_checksum_error_enable_reject: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      token_checksum_error_enable_fail_in |=> flags_reg[`UES_BIT_TOKEN_CHECKSUM_ERROR_ENABLE] && packet_reject_out)
      else $error("Token checksum failure not flagged and rejected.");

   a_pid_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      pid_fail_in |=> flags_reg[`UES_BIT_PID])
      else $error("Identifier check failure not flagged.");

   a_timeout_cause: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ($rose(flags_reg[`UES_BIT_TIMEOUT]))
      |-> ($past(ta_cnt_reg) == `UES_TA_BITS) && $past(bus_idle_in))
      else $error("Turnaround timeout without 16 idle bit times.");

   a_timer_stop: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (ta_state_reg == UES_TA_RUN && !bus_idle_in) |=> (ta_state_reg == UES_TA_IDLE))
      else $error("Turnaround timer kept running after bus activity.");

   a_enable_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      wr_enables |=> (enables_reg == ($past(wr_data_in) & `UES_IMPL_MASK)))
      else $error("Enable register did not take the written value.");

   c_stuff_err: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      bit_stuff_err_in ##1 packet_reject_out);

   c_timeout: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      ta_timeout);

   c_truncate: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      buf_overrun ##1 !store_byte_out);

   c_irq: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      $rose(error_irq_out));

endmodule

`default_nettype wire

// file: bench/ues_host_model.sv
// Purpose: Host side of the bus, turning bench requests into error events.
// Assumes: Requests are one-cycle pulses on clk_in.
// Notes:   Outputs are registered, so events reach the block one cycle late.
`timescale 1ns/100ps
`default_nettype none
module ues_host_model (
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic [7:0] ev_in,
   input  wire logic       eop_req_in,
   input  wire logic       reply_in,
   input  wire logic       busy_in,
   output logic            stuff_out,
   output logic            late_out,
   output logic            eop_rx_out,
   output logic [2:0]      residue_out,
   output logic            data_checksum_error_enable_out,
   output logic            token_checksum_error_enable_out,
   output logic            pid_out,
   output logic            eop_out,
   output logic            expect_out,
   output logic            idle_out
);
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         {stuff_out, late_out, eop_rx_out, data_checksum_error_enable_out, token_checksum_error_enable_out, pid_out} <= 6'h00;
         residue_out <= 3'h0;
         {eop_out, expect_out} <= 2'h0;
         idle_out <= 1'b1;
      end else begin
         stuff_out <= ev_in[7];
         late_out <= ev_in[5];
         eop_rx_out <= ev_in[3] || ev_in[6];
         residue_out <= ev_in[3] ? 3'($urandom_range(1, 7))
                        : (ev_in[6] ? 3'h0 : ~residue_out);
         data_checksum_error_enable_out <= ev_in[2];
         token_checksum_error_enable_out <= ev_in[1];
         pid_out <= ev_in[0];
         eop_out <= eop_req_in;
         expect_out <= reply_in;
         idle_out <= ~busy_in;
      end
   end
endmodule
`default_nettype wire

// file: bench/tb_usb_error_status_enable.sv
// Purpose: Self-checking bench for the error flags, enables and summary bit.
// Assumes: Host model drives the bus events; bench drives registers and bytes.
// Notes:   A reference model in integers predicts every read and output.
`timescale 1ns/100ps
`default_nettype none
`include "ues_regs.svh"
module tb_usb_error_status_enable;
   import ues_pkg::*;
   logic       clk_in = 1'b0;
   logic       rst_n_in = 1'b0;
   logic [1:0] addr = 2'h0;
   ues_byte_t  wdata = 8'h00;
   logic       wr_en = 1'b0;
   logic       rd_en = 1'b0;
   logic [7:0] ev = 8'h00;
   logic       eop_req = 1'b0;
   logic       reply = 1'b0;
   logic       busy = 1'b0;
   logic       pstart = 1'b0;
   logic       rx_byte = 1'b0;
   logic [9:0] bd_size = 10'h000;
   ues_byte_t  rd_data;
   logic       stuff, late, eop_rx, data_checksum_error_enable, token_checksum_error_enable, pid, eop, expect_l, idle;
   logic       store, reject, summary, irq;
   logic [2:0] residue;
   int         errors = 0, n_checks = 0, seed;
   int         flags_m = 0, en_m = 0, men_m = 0;
   ////////////////////////////////////////////////////////////////////////////
   ues_host_model host (.clk_in(clk_in), .rst_n_in(rst_n_in), .ev_in(ev),
      .eop_req_in(eop_req), .reply_in(reply), .busy_in(busy), .stuff_out(stuff),
      .late_out(late), .eop_rx_out(eop_rx), .residue_out(residue), .data_checksum_error_enable_out(data_checksum_error_enable),
      .token_checksum_error_enable_out(token_checksum_error_enable), .pid_out(pid), .eop_out(eop), .expect_out(expect_l),
      .idle_out(idle));
   ues_error_status dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr),
      .wr_data_in(wdata), .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rd_data),
      .bit_stuff_err_in(stuff), .bd_fetch_late_in(late), .packet_start_in(pstart),
      .rx_byte_in(rx_byte), .bd_size_in(bd_size), .rx_eop_in(eop_rx),
      .rx_bit_residue_in(residue), .data_checksum_error_enable_fail_in(data_checksum_error_enable), .token_checksum_error_enable_fail_in(token_checksum_error_enable),
      .pid_fail_in(pid), .eop_in(eop), .turnaround_expect_in(expect_l),
      .bus_idle_in(idle), .store_byte_out(store), .packet_reject_out(reject),
      .summary_error_flag_out(summary), .error_irq_out(irq));
   ////////////////////////////////////////////////////////////////////////////
   function automatic int summ();
      return int'((flags_m & en_m) != 0);
   endfunction
   task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [1:0] a, input ues_byte_t d);
      @(posedge clk_in);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk_in);
      wr_en <= 1'b0;
      if (a == `UES_OFS_FLAGS) flags_m &= ~int'(d);
      if (a == `UES_OFS_ENABLES) en_m = int'(d & 8'hBF);
      if (a == `UES_OFS_MAIN_EN) men_m = int'(d & 8'h02);
   endtask
   task automatic rd(input logic [1:0] a, input int exp);
      @(posedge clk_in);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk_in);
      rd_en <= 1'b0;
      #1;
      chk("rd_data", {2'h0, rd_data}, 10'(exp));
   endtask
   task automatic outs();
      chk("summary", {9'h0, summary}, 10'(summ()));
      chk("irq", {9'h0, irq}, 10'(summ() & men_m[1]));
   endtask
   task automatic fire(input logic [7:0] m);
      @(posedge clk_in);
      ev <= m;
      @(posedge clk_in);
      ev <= 8'h00;
      @(posedge clk_in);
      #1;
      flags_m |= int'(m & 8'hAF);
      chk("reject", {9'h0, reject}, 10'(|(m & 8'h86)));
   endtask
   task automatic byte_in(input logic fits);
      @(posedge clk_in);
      rx_byte <= 1'b1;
      @(posedge clk_in);
      rx_byte <= 1'b0;
      #1;
      chk("store", {9'h0, store}, {9'h0, fits});
      if (!fits) flags_m |= 32'h20;
   endtask
   task automatic turn(input logic rep, input int busy_at, input int n, input logic exp);
      @(posedge clk_in);
      eop_req <= 1'b1;
      reply <= rep;
      @(posedge clk_in);
      eop_req <= 1'b0;
      for (int c = 0; c < n; c++) begin
         @(posedge clk_in);
         busy <= (c == busy_at);
      end
      if (exp) flags_m |= 32'h10;
      rd(`UES_OFS_FLAGS, flags_m);
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #5 clk_in = ~clk_in;
   end
   initial begin
      #100000;
      errors++;
      test_done();
   end
   initial begin
      seed = $urandom(6243);
      repeat (5) @(posedge clk_in);
      rst_n_in <= 1'b1;
      for (int a = 0; a < 4; a++) rd(2'(a), 0);
      for (int i = 0; i < 12; i++) begin
         wr(`UES_OFS_ENABLES, 8'($urandom));
         wr(`UES_OFS_MAIN_EN, 8'($urandom));
         rd(`UES_OFS_ENABLES, en_m);
         fire((i < 8) ? 8'h01 << i : 8'($urandom));
         outs();
         rd(`UES_OFS_FLAGS, flags_m);
         rd(`UES_OFS_MAIN_FLG, summ() << 1);
         wr(`UES_OFS_FLAGS, 8'($urandom));
         rd(`UES_OFS_FLAGS, flags_m);
         outs();
      end
      wr(`UES_OFS_MAIN_FLG, 8'hFF);
      rd(`UES_OFS_MAIN_FLG, summ() << 1);
      rd(`UES_OFS_MAIN_EN, men_m);
      for (int p = 0; p < 2; p++) begin
         @(posedge clk_in);
         bd_size <= 10'($urandom_range(1, 4));
         pstart <= 1'b1;
         @(posedge clk_in);
         pstart <= 1'b0;
         for (int b = 0; b < 6; b++) byte_in(b < bd_size);
         rd(`UES_OFS_FLAGS, flags_m);
         wr(`UES_OFS_FLAGS, 8'hFF);
      end
      turn(1'b1, -1, 141, 1'b0);
      turn(1'b1, -1, 40, 1'b1);
      outs();
      wr(`UES_OFS_FLAGS, 8'h10);
      turn(1'b1, 60, 200, 1'b0);
      turn(1'b0, -1, 200, 1'b0);
      test_done();
   end
endmodule
`default_nettype wire
